// file: inc/fce_params.svh
// Offsets, field positions, reset values and counts for the conversion entry block
`ifndef FCE_PARAMS_SVH
`define FCE_PARAMS_SVH

// Register byte offsets
`define FCE_OFF_SETUP1     12'h000
`define FCE_OFF_SETUP2     12'h004
`define FCE_OFF_SETUP3     12'h008
`define FCE_OFF_RESULT     12'h00C
`define FCE_OFF_STATUS     12'h010

// Reset values
`define FCE_SETUP1_RST     24'h000000
`define FCE_SETUP2_RST     24'h000000
`define FCE_SETUP3_RST     24'h000000

// Method digit and field positions of the first setup word
`define FCE_METHOD_HI      23
`define FCE_METHOD_LO      20
`define FCE_OPT_BIT        19
`define FCE_ADDR_HI        15
`define FCE_METHOD_FILTER  4'hD
`define FCE_METHOD_RESOLV  4'hE
`define FCE_METHOD_INTERP  4'hF

// Entry sizes in table lines
`define FCE_LINES_EXP      3'h3
`define FCE_LINES_TRACK    3'h5

// Filter gain scaling exponent
`define FCE_GAIN_SHIFT     23

// Angle word: 17 bits, 12 count bits above 5 fraction bits
`define FCE_ANG_W          17
`define FCE_CYC_W          7
`define FCE_FRAC_LO        5

`endif

// file: inc/fce_pkg.sv
// Types shared by the conversion entry block
package fce_pkg;

    typedef enum logic [1:0] {
        FCE_ST_IDLE,
        FCE_ST_ROT,
        FCE_ST_DONE
    } fce_state_t;

    typedef struct packed {
        logic signed [23:0] lim;
        logic signed [23:0] out;
    } fce_filt_t;

    typedef struct packed {
        logic signed [17:0] x;
        logic signed [17:0] y;
        logic        [16:0] z;
    } fce_vec_t;

endpackage

// file: hw/fce_conversion_entry.sv
// Conversion table entry engine: exponential filter, resolver and interpolator
//
// Contract
// - Bit 19 of setup word one picks exponential or tracking filter; with bit 19 set the code produces no filter result.
// - Exponential entry spans three lines, tracking entry five lines.
// - New output is old output plus K/2^23 times input-output difference.
// - Input step beyond max-change is clamped to prior value plus or minus it.
// - Values are signed 24-bit; difference truncated to 24 bits for wraparound.
// - Filter source read unshifted from address in setup word one low bits.
// - Filter setup word one holds D, then zero, then source address.
// - Max-change limit comes from setup word two, in input units.
// - Gain K comes from setup word three.
// - Filter output lands in the entry's third-line result word.
// - Resolver word holds E and first ADC address; second ADC is next.
// - Resolver bit 19 selects clockwise or counter-clockwise angle sense.
// - Resolver setup word two low bits give excitation register address.
// - Resolver setup word three holds signed 12-bit sine and cosine biases.
// - Each bias adds to the top 12 bits of its ADC reading.
// - Top 12 angle bits sit in result bits 5 to 16.
// - Result bits 0 to 4 carry extra fractional angle resolution.
// - Result bits 17 to 23 count resolver cycles via wrap detection.
// - Interpolator word holds F and encoder base; bit 19 picks layout.
// - Interpolator joins line count and sub-line angle, 4096 per line.
// - Interpolator setup word two gives first ADC; second ADC is next.
// - Interpolator result LSB is one 4096th of an encoder line.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "fce_params.svh"

module fce_conversion_entry import fce_pkg::*; #(
    parameter int CORDIC_ITERS = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        servo_tick,
    input  wire logic [23:0] src_value,
    input  wire logic [23:0] adc_sin,
    input  wire logic [23:0] adc_cos,
    output logic      [15:0] src_addr,
    output logic      [15:0] adc_addr_a,
    output logic      [15:0] adc_addr_b,
    output logic      [15:0] exc_addr,
    output logic             layout_alt,
    output logic      [23:0] result_word,
    output logic             result_valid
);

    generate
        if (CORDIC_ITERS < 1 || CORDIC_ITERS > 16) begin : g_bad_iters
            $error("CORDIC_ITERS must be 1 to 16");
        end
    endgenerate

    // =========================================================
    // Functions
    // =========================================================
    // Angle step per iteration, full circle is 2^17
    function automatic logic [16:0] atan_step(input logic [3:0] i);
        unique case (i)
            4'h0: atan_step = 17'h04000;
            4'h1: atan_step = 17'h025C8;
            4'h2: atan_step = 17'h013F6;
            4'h3: atan_step = 17'h00A22;
            4'h4: atan_step = 17'h00516;
            4'h5: atan_step = 17'h0028C;
            4'h6: atan_step = 17'h00146;
            4'h7: atan_step = 17'h000A3;
            4'h8: atan_step = 17'h00051;
            4'h9: atan_step = 17'h00029;
            4'hA: atan_step = 17'h00014;
            4'hB: atan_step = 17'h0000A;
            4'hC: atan_step = 17'h00005;
            4'hD: atan_step = 17'h00003;
            4'hE: atan_step = 17'h00001;
            4'hF: atan_step = 17'h00001;
        endcase
    endfunction

    // Top 14 ADC bits with a 12-bit bias added at the top 12 bits
    function automatic logic signed [17:0] bias_adc(input logic [23:0] adc,
                                                    input logic [11:0] bias);
        logic signed [13:0] s;
        s = $signed(adc[23:10]) + $signed({bias, 2'h0});
        bias_adc = 18'(s);
    endfunction

    // Slew-limited exponential filter step
    function automatic fce_filt_t exp_step(input logic signed [23:0] in_v,
                                           input logic signed [23:0] prev,
                                           input logic signed [23:0] outp,
                                           input logic signed [23:0] maxc,
                                           input logic signed [23:0] k);
        logic signed [23:0] d;
        logic signed [23:0] e;
        logic signed [47:0] p;
        fce_filt_t          r;
        d = in_v - prev;
        if (d > maxc) begin
            r.lim = prev + maxc;
        end else if (d < -maxc) begin
            r.lim = prev - maxc;
        end else begin
            r.lim = in_v;
        end
        e = r.lim - outp;
        p = 48'(e) * 48'(k);
        r.out = outp + 24'(p >>> `FCE_GAIN_SHIFT);
        exp_step = r;
    endfunction

    // =========================================================
    // State
    // =========================================================
    fce_state_t         state, next_state;
    logic        [23:0] setup1, next_setup1;
    logic        [23:0] setup2, next_setup2;
    logic        [23:0] setup3, next_setup3;
    logic        [23:0] next_result_word;
    logic               next_result_valid;
    logic signed [23:0] prev_in, next_prev_in;
    logic signed [23:0] filt_out, next_filt_out;
    logic [`FCE_CYC_W-1:0] cyc, next_cyc;
    logic        [16:0] prev_ang, next_prev_ang;
    fce_vec_t           vec, next_vec;
    logic         [3:0] iter, next_iter;
    logic        [31:0] next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    // Synchroniser: tick_s1 feeds only tick_s2
    logic               tick_s1;
    logic               tick_s2;
    logic               tick_d;
    logic         [3:0] method;
    logic               opt;
    logic         [2:0] lines;
    logic               tick_rise;

    assign method    = setup1[`FCE_METHOD_HI:`FCE_METHOD_LO];
    assign opt       = setup1[`FCE_OPT_BIT];
    assign lines     = opt ? `FCE_LINES_TRACK : `FCE_LINES_EXP;
    assign tick_rise = tick_s2 & ~tick_d;

    // =========================================================
    // Next values
    // =========================================================
    always_comb begin
        logic               acc;
        logic        [16:0] ang;
        logic signed [17:0] xs;
        logic signed [17:0] ys;
        logic signed [17:0] si;
        logic signed [17:0] co;
        fce_filt_t          f;
        acc = psel & penable;
        ang = '0;
        xs  = '0;
        ys  = '0;
        si  = '0;
        co  = '0;
        f   = '0;
        next_state        = state;
        next_setup1       = setup1;
        next_setup2       = setup2;
        next_setup3       = setup3;
        next_result_word  = result_word;
        next_result_valid = 1'b0;
        next_prev_in      = prev_in;
        next_filt_out     = filt_out;
        next_cyc          = cyc;
        next_prev_ang     = prev_ang;
        next_vec          = vec;
        next_iter         = iter;
        next_prdata       = prdata;
        next_pslverr      = 1'b0;
        // One wait state so every bus output comes from a flop
        next_pready       = acc & ~pready;

        if (acc & ~pready) begin
            next_prdata = 32'h0;
            unique case (paddr)
                `FCE_OFF_SETUP1: next_prdata = {8'h00, setup1};
                `FCE_OFF_SETUP2: next_prdata = {8'h00, setup2};
                `FCE_OFF_SETUP3: next_prdata = {8'h00, setup3};
                `FCE_OFF_RESULT: next_prdata = {8'h00, result_word};
                `FCE_OFF_STATUS: next_prdata = {21'h0, cyc, lines,
                                                state != FCE_ST_IDLE};
                default:         next_pslverr = 1'b1;
            endcase
        end
        if (acc & pready & pwrite) begin
            unique case (paddr)
                `FCE_OFF_SETUP1: next_setup1 = pwdata[23:0];
                `FCE_OFF_SETUP2: next_setup2 = pwdata[23:0];
                `FCE_OFF_SETUP3: next_setup3 = pwdata[23:0];
                default:         next_setup1 = setup1;
            endcase
        end

        unique case (state)
            FCE_ST_IDLE: begin
                if (tick_rise) begin
                    if (method == `FCE_METHOD_FILTER) begin
                        if (!opt) begin
                            f = exp_step(src_value, prev_in, filt_out,
                                         setup2, setup3);
                            next_prev_in      = f.lim;
                            next_filt_out     = f.out;
                            next_result_word  = f.out;
                            next_result_valid = 1'b1;
                        end
                    end else if (method == `FCE_METHOD_RESOLV ||
                                 method == `FCE_METHOD_INTERP) begin
                        si = bias_adc(adc_sin, setup3[23:12]);
                        co = bias_adc(adc_cos, setup3[11:0]);
                        // Fold into right half plane before rotating
                        if (co < 0) begin
                            next_vec.x = -co;
                            next_vec.y = -si;
                            next_vec.z = 17'h10000;
                        end else begin
                            next_vec.x = co;
                            next_vec.y = si;
                            next_vec.z = 17'h00000;
                        end
                        next_iter  = 4'h0;
                        next_state = FCE_ST_ROT;
                    end
                end
            end
            FCE_ST_ROT: begin
                xs = vec.x >>> iter;
                ys = vec.y >>> iter;
                if (vec.y >= 0) begin
                    next_vec.x = vec.x + ys;
                    next_vec.y = vec.y - xs;
                    next_vec.z = vec.z + atan_step(iter);
                end else begin
                    next_vec.x = vec.x - ys;
                    next_vec.y = vec.y + xs;
                    next_vec.z = vec.z - atan_step(iter);
                end
                next_iter = iter + 4'h1;
                if (iter == 4'(CORDIC_ITERS - 1)) begin
                    next_state = FCE_ST_DONE;
                end
            end
            FCE_ST_DONE: begin
                next_state = FCE_ST_IDLE;
                if (method == `FCE_METHOD_RESOLV) begin
                    ang = opt ? vec.z : 17'(-vec.z);
                    if (prev_ang[16:15] == 2'h3 && ang[16:15] == 2'h0) begin
                        next_cyc = cyc + 7'h01;
                    end else if (prev_ang[16:15] == 2'h0 &&
                                 ang[16:15] == 2'h3) begin
                        next_cyc = cyc - 7'h01;
                    end
                    next_prev_ang    = ang;
                    next_result_word = {next_cyc, ang};
                end else begin
                    next_result_word = {src_value[11:0],
                                        vec.z[16:`FCE_FRAC_LO]};
                end
                next_result_valid = 1'b1;
            end
        endcase
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= FCE_ST_IDLE;
            setup1       <= `FCE_SETUP1_RST;
            setup2       <= `FCE_SETUP2_RST;
            setup3       <= `FCE_SETUP3_RST;
            result_word  <= 24'h000000;
            result_valid <= 1'b0;
            prev_in      <= 24'sh000000;
            filt_out     <= 24'sh000000;
            cyc          <= 7'h00;
            prev_ang     <= 17'h00000;
            vec          <= '0;
            iter         <= 4'h0;
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            tick_s1      <= 1'b0;
            tick_s2      <= 1'b0;
            tick_d       <= 1'b0;
            src_addr     <= 16'h0000;
            adc_addr_a   <= 16'h0000;
            adc_addr_b   <= 16'h0000;
            exc_addr     <= 16'h0000;
            layout_alt   <= 1'b0;
        end else begin
            state        <= next_state;
            setup1       <= next_setup1;
            setup2       <= next_setup2;
            setup3       <= next_setup3;
            result_word  <= next_result_word;
            result_valid <= next_result_valid;
            prev_in      <= next_prev_in;
            filt_out     <= next_filt_out;
            cyc          <= next_cyc;
            prev_ang     <= next_prev_ang;
            vec          <= next_vec;
            iter         <= next_iter;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
            tick_s1      <= servo_tick;
            tick_s2      <= tick_s1;
            tick_d       <= tick_s2;
            src_addr     <= setup1[`FCE_ADDR_HI:0];
            adc_addr_a   <= (method == `FCE_METHOD_RESOLV) ?
                            setup1[15:0] : setup2[15:0];
            adc_addr_b   <= ((method == `FCE_METHOD_RESOLV) ?
                            setup1[15:0] : setup2[15:0]) + 16'h0001;
            exc_addr     <= setup2[15:0];
            layout_alt   <= opt;
        end
    end

endmodule // fce_conversion_entry

// file: verif/fce_src_model.sv
// Source register and ADC word model facing the engine
`timescale 1ns/100ps
module fce_src_model (
    input  wire logic        pclk,
    input  wire logic [15:0] src_addr,
    input  wire logic [15:0] adc_addr_a,
    input  wire logic [15:0] adc_addr_b,
    output logic      [23:0] src_value,
    output logic      [23:0] adc_sin,
    output logic      [23:0] adc_cos
);
    logic [23:0] xmem [logic [15:0]];
    logic [23:0] ymem [logic [15:0]];
    // ====
    // Reads, moved off the sampling edge
    // Unwritten places give a pattern, never a stale word
    always @(negedge pclk) begin
        src_value = xmem.exists(src_addr) ? xmem[src_addr] : 24'hA5A5A5;
        adc_sin   = ymem.exists(adc_addr_a) ? ymem[adc_addr_a] : 24'hA5A5A5;
        adc_cos   = ymem.exists(adc_addr_b) ? ymem[adc_addr_b] : 24'h5A5A5A;
    end
endmodule // fce_src_model

// file: verif/fce_conversion_entry_chk.sv
// Port assertions for the conversion entry engine
`timescale 1ns/100ps
module fce_conversion_entry_chk #(
    parameter int CORDIC_ITERS = 16
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        servo_tick,
    input wire logic [15:0] src_addr,
    input wire logic [15:0] adc_addr_a,
    input wire logic [15:0] adc_addr_b,
    input wire logic [15:0] exc_addr,
    input wire logic        layout_alt,
    input wire logic [23:0] result_word,
    input wire logic        result_valid
);
    localparam logic [7:0] LONG_LO = 8'(CORDIC_ITERS + 3);
    localparam logic [7:0] LONG_HI = 8'(CORDIC_ITERS + 5);
    logic       tick_q;
    logic       wr_s1;
    logic       wr_s2;
    logic [7:0] since;
    logic [7:0] next_since;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_s1 = psel && penable && pready && pwrite && paddr == 12'h000;
    assign wr_s2 = psel && penable && pready && pwrite && paddr == 12'h004;
    // ====
    // Age of the last tick, saturating
    always_comb begin
        next_since = (since == 8'hFF) ? since : since + 8'h01;
        if (servo_tick && !tick_q) begin
            next_since = 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since  <= 8'hFF;
            tick_q <= 1'b0;
        end else begin
            since  <= next_since;
            tick_q <= servo_tick;
        end
    end
    // ====
    // Assertions
    property p_apb_wait;
        psel && !penable |=> penable && !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("access not one wait state");
    property p_refuse;
        psel && penable && pready && paddr > 12'h010 |-> pslverr && prdata == 32'h0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    property p_src_addr;
        wr_s1 |-> ##2 src_addr == $past(pwdata[15:0], 2);
    endproperty
    a_src_addr: assert property (p_src_addr) else $error("source address wrong");
    property p_layout;
        wr_s1 |-> ##2 layout_alt == $past(pwdata[19], 2);
    endproperty
    a_layout: assert property (p_layout) else $error("layout bit wrong");
    property p_exc;
        wr_s2 |-> ##2 exc_addr == $past(pwdata[15:0], 2);
    endproperty
    a_exc: assert property (p_exc) else $error("excitation address wrong");
    property p_pair;
        result_valid |-> adc_addr_b == adc_addr_a + 16'h0001;
    endproperty
    a_pair: assert property (p_pair) else $error("second ADC not next address");
    property p_hold;
        !result_valid |-> $stable(result_word);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without valid");
    property p_latency;
        result_valid |-> (since >= 8'h02 && since <= 8'h04) ||
                         (since >= LONG_LO && since <= LONG_HI);
    endproperty
    a_latency: assert property (p_latency) else $error("result at wrong time");
    property p_reset;
        $rose(presetn) |-> result_word == 24'h000000 && !result_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("result not cleared");
endmodule // fce_conversion_entry_chk

bind fce_conversion_entry fce_conversion_entry_chk #(.CORDIC_ITERS(CORDIC_ITERS)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_tick(servo_tick), .src_addr(src_addr), .adc_addr_a(adc_addr_a),
    .adc_addr_b(adc_addr_b), .exc_addr(exc_addr), .layout_alt(layout_alt),
    .result_word(result_word), .result_valid(result_valid));

// file: verif/tb_fce_conversion_entry.sv
// Self-checking bench for the conversion entry engine
`timescale 1ns/100ps
module tb_fce_conversion_entry;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               servo_tick, layout_alt, result_valid;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata;
    logic        [23:0] src_value, adc_sin, adc_cos, result_word;
    logic        [15:0] src_addr, adc_addr_a, adc_addr_b, exc_addr;
    int                 err_total, total_checks, vcount, nv;
    logic signed [23:0] f_prev, f_out;
    logic         [6:0] r_cyc;
    logic         [1:0] r_top;
    fce_conversion_entry fce_conversion_entry_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_tick(servo_tick), .src_value(src_value), .adc_sin(adc_sin), .adc_cos(adc_cos),
        .src_addr(src_addr), .adc_addr_a(adc_addr_a), .adc_addr_b(adc_addr_b),
        .exc_addr(exc_addr), .layout_alt(layout_alt), .result_word(result_word),
        .result_valid(result_valid));
    fce_src_model fce_src_model_i (
        .pclk(pclk), .src_addr(src_addr), .adc_addr_a(adc_addr_a), .adc_addr_b(adc_addr_b),
        .src_value(src_value), .adc_sin(adc_sin), .adc_cos(adc_cos));
    // ====
    // Compare, bus and tick tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Arctangent is approximate: allow a few fraction steps
    task automatic chk_near(input logic [16:0] got, input logic [16:0] exp, input string what);
        logic [16:0] d;
        d = got - exp;
        total_checks++;
        if ($isunknown(got) || (d > 17'h00008 && d < 17'h1FFF8)) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed latency: only the watchdog ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [23:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {8'h00, d}, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, "read data");
        chk({31'h0, e}, {31'h0, ee}, "slave error");
    endtask
    task automatic tick(output int n);
        int v0;
        v0 = vcount;
        servo_tick <= 1'b1;
        repeat (4) @(posedge pclk);
        servo_tick <= 1'b0;
        repeat (24) @(posedge pclk);
        n = vcount - v0;
    endtask
    always @(posedge pclk) begin
        if (result_valid === 1'b1) begin
            vcount++;
        end
    end
    // Expected filter step uses the clamped input as next prior value
    task automatic filt(input logic signed [23:0] inp, input logic signed [23:0] mc);
        logic signed [23:0] d;
        logic signed [47:0] p;
        d = inp - f_prev;
        f_prev = (d > mc) ? f_prev + mc : (d < -mc) ? f_prev - mc : inp;
        d = f_prev - f_out;
        p = d * 48'sh100000;
        f_out = f_out + 24'(p >>> 23);
        fce_src_model_i.xmem[16'h0723] = inp;
        tick(nv);
        chk(32'(nv), 32'h1, "filter results");
        chk({8'h00, result_word}, {8'h00, f_out}, "filter output");
    endtask
    // Raw words carry the offset that the bias word removes
    task automatic adc(input logic [15:0] a, input logic sn, input logic cn);
        fce_src_model_i.ymem[a] = (sn ? 24'hE00000 : 24'h200000) + 24'h100000;
        fce_src_model_i.ymem[a + 16'h0001] = (cn ? 24'hE00000 : 24'h200000) - 24'h100000;
    endtask
    task automatic res(input logic sn, input logic [16:0] ang);
        adc(16'hFF00, sn, 1'b0);
        r_cyc = r_cyc + ((r_top == 2'b11 && ang[16:15] == 2'b00) ? 7'h01
                      : (r_top == 2'b00 && ang[16:15] == 2'b11) ? 7'h7F : 7'h00);
        r_top = ang[16:15];
        tick(nv);
        chk(32'(nv), 32'h1, "resolver results");
        chk({25'h0, result_word[23:17]}, {25'h0, r_cyc}, "cycle count");
        chk_near(result_word[16:0], ang, "angle");
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ====
    // Clock, watchdog and tests
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, servo_tick} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {err_total, total_checks, vcount} = '0;
        {f_prev, f_out, r_cyc, r_top} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h00C, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        wr(12'h000, 24'hD00723);
        wr(12'h004, 24'h0003E8);
        wr(12'h008, 24'h100000);
        rd(12'h000, 32'h00D00723, 1'b0);
        rd(12'h010, 32'h00000006, 1'b0);
        filt(24'sh0001F4, 24'sh0003E8);
        filt(24'sh001388, 24'sh0003E8);
        filt(-24'sh0000C8, 24'sh0003E8);
        chk({16'h0, src_addr}, 32'h0723, "source address");
        wr(12'h00C, 24'h123456);
        rd(12'h00C, {8'h00, f_out}, 1'b0);
        wr(12'h004, 24'h7FFFFF);
        filt(24'sh7FFF00, 24'sh7FFFFF);
        filt(24'sh800100, 24'sh7FFFFF);
        wr(12'h000, 24'hD80723);
        rd(12'h010, 32'h0000000A, 1'b0);
        tick(nv);
        chk(32'(nv), 32'h0, "tracking results");
        wr(12'h000, 24'hE8FF00);
        wr(12'h004, 24'h00FF5C);
        wr(12'h008, 24'hF00100);
        res(1'b1, 17'h1C000);
        res(1'b0, 17'h04000);
        chk({16'h0, adc_addr_a}, 32'hFF00, "first ADC");
        chk({16'h0, exc_addr}, 32'hFF5C, "excitation");
        wr(12'h000, 24'hE0FF00);
        res(1'b0, 17'h1C000);
        wr(12'h000, 24'hF8C000);
        wr(12'h004, 24'h00FF20);
        adc(16'hFF20, 1'b0, 1'b0);
        fce_src_model_i.xmem[16'hC000] = 24'h123ABC;
        tick(nv);
        chk({20'h0, result_word[23:12]}, 32'hABC, "line count");
        chk_near({5'h00, result_word[11:0]}, 17'h00200, "sub-line");
        chk({adc_addr_b, adc_addr_a}, 32'hFF21FF20, "ADC pair");
        chk({31'h0, layout_alt}, 32'h1, "layout");
        rd(12'h010, 32'h000007FA, 1'b0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h00C, 32'h0, 1'b0);
        rd(12'h010, 32'h00000006, 1'b0);
        tally_and_finish();
    end
endmodule // tb_fce_conversion_entry
